// *** src/rsdc_uart_tx.v ***
// What this block does
// - auto mode drives line while data waits
// - request-to-send only steers transceiver direction
// - clear-to-send treated as always asserted
// - status bit five shows the holding buffer has room
// - divisor gives rates from about 48 to 3125000 on a 50 MHz core clock
// - register block placed on any eight-byte boundary in 000-3ff
// - auto mode ignores request-to-send bit
// - low control bits set width and stops
//
// transmit side of an isa-style byte uart with rs485 direction pin
// assumes io_base_i is static and the bus strobes are one-cycle pulses
// on core_clk_i; receive path is not part of this block
`timescale 1ns/1ns
`include "rsdc_consts.vh"
module rsdc_uart_tx #(
   parameter DIV_W = 16
) (
   input wire core_clk_i,
   input wire srst_i,
   input wire [9:0] io_base_i,
   input wire [9:0] io_addr_i,
   input wire io_wr_i,
   input wire io_rd_i,
   input wire [7:0] io_wdata_i,
   output reg [7:0] io_rdata_o,
   input wire cts_n_i,
   output reg txd_o,
   output reg drv_en_o,
   output wire rts_o
);
   localparam ST_IDLE = 2'd0;
   localparam ST_START = 2'd1;
   localparam ST_DATA = 2'd2;
   localparam ST_STOP = 2'd3;

   reg [7:0] line_ctrl;
   reg [7:0] modem_control;
   reg [7:0] scratch;
   reg [DIV_W-1:0] divisor;
   reg [1:0] state;
   reg [7:0] shift;
   reg [2:0] bit_idx;
   reg [2:0] width_m1;
   reg two_stops;
   reg stop_idx;
   reg [DIV_W+3:0] tick_cnt;
   reg [2:0] cts_sync;
   wire sel;
   wire [2:0] ofs;
   wire divisor_latch_access_bit;
   wire buf_in_ready;
   wire buf_valid;
   wire [7:0] buf_data;
   wire buf_pop;
   wire tick;
   wire auto_mode;
   wire busy;
   wire [7:0] line_status;

   // match the eight-byte window at any eight-aligned base inside the 10-bit space
   function hit;
      input [9:0] addr;
      input [9:0] base;
      begin
         hit = (addr[9:3] == base[9:3]);
      end
   endfunction

   assign sel = hit(io_addr_i, io_base_i);
   assign ofs = io_addr_i[2:0];
   assign divisor_latch_access_bit = line_ctrl[`RSDC_LCR_DIVISOR_LATCH_ACCESS_BIT];
   assign auto_mode = modem_control[`RSDC_MCR_AUTO];
   assign busy = (state != ST_IDLE);
   // the bit only reaches the direction pin, never the line
   assign rts_o = modem_control[`RSDC_MCR_RTS];

   // register writes; divisor shares offsets 0 and 1 under divisor_latch_access_bit
   always @(posedge core_clk_i) begin
      if (srst_i) begin
         divisor <= `RSDC_RST_DIV;
         line_ctrl <= `RSDC_RST_LCR;
         modem_control <= `RSDC_RST_MCR;
         scratch <= 8'h00;
      end else if (io_wr_i & sel) begin
         case (ofs)
            `RSDC_OFS_DATA: begin
               if (divisor_latch_access_bit)
                  divisor[7:0] <= io_wdata_i;
            end
            `RSDC_OFS_DIVHI: begin
               if (divisor_latch_access_bit)
                  divisor[DIV_W-1:8] <= io_wdata_i[DIV_W-9:0];
            end
            `RSDC_OFS_LCTRL: line_ctrl <= io_wdata_i;
            `RSDC_OFS_MCTRL: modem_control <= io_wdata_i;
            `RSDC_OFS_SCRATCH: scratch <= io_wdata_i;
            default: scratch <= scratch;
         endcase
      end
   end

   // data writes go into the buffer; dropped only when full
   rsdc_buf2 #(
      .WIDTH(8)
   ) u_buf (
      .core_clk_i(core_clk_i),
      .srst_i(srst_i),
      .in_valid_i(io_wr_i & sel & (ofs == `RSDC_OFS_DATA) & ~divisor_latch_access_bit),
      .in_ready_o(buf_in_ready),
      .in_data_i(io_wdata_i),
      .out_valid_o(buf_valid),
      .out_ready_i(buf_pop),
      .out_data_o(buf_data)
   );

   assign line_status = {1'b0, ~buf_valid & ~busy, buf_in_ready, 5'h00};

   // register reads
   always @(posedge core_clk_i) begin
      if (srst_i) begin
         io_rdata_o <= 8'h00;
      end else if (io_rd_i & sel) begin
         case (ofs)
            `RSDC_OFS_DATA: io_rdata_o <= divisor_latch_access_bit ? divisor[7:0] : 8'h00;
            `RSDC_OFS_DIVHI: begin
               if (divisor_latch_access_bit)
                  io_rdata_o <= divisor[DIV_W-1:8];
               else
                  io_rdata_o <= 8'h00;
            end
            `RSDC_OFS_LCTRL: io_rdata_o <= line_ctrl;
            `RSDC_OFS_MCTRL: io_rdata_o <= modem_control;
            `RSDC_OFS_LSTAT: io_rdata_o <= line_status;
            `RSDC_OFS_SCRATCH: io_rdata_o <= scratch;
            default: io_rdata_o <= 8'h00;
         endcase
      end
   end

   // clear-to-send synchronised but not used to gate sending
   always @(posedge core_clk_i) begin
      if (srst_i)
         cts_sync <= 3'b000;
      else
         cts_sync <= {cts_sync[1:0], ~cts_n_i};
   end

   // bit period is divisor times sixteen core cycles
   assign tick = (tick_cnt == 20'd0) & busy;
   always @(posedge core_clk_i) begin
      if (srst_i | ~busy)
         tick_cnt <= {divisor, 4'h0} - 20'd1;
      else if (tick_cnt == 20'd0)
         tick_cnt <= {divisor, 4'h0} - 20'd1;
      else
         tick_cnt <= tick_cnt - 20'd1;
   end

   // shifter pops only when idle and not in divisor setup
   assign buf_pop = ~busy & ~divisor_latch_access_bit & buf_valid;

   // frame: start, 5..8 data lsb first, one or two stops
   always @(posedge core_clk_i) begin
      if (srst_i) begin
         state <= ST_IDLE;
         txd_o <= 1'b1;
         shift <= 8'h00;
         bit_idx <= 3'd0;
         width_m1 <= 3'd7;
         two_stops <= 1'b0;
         stop_idx <= 1'b0;
      end else begin
         case (state)
            ST_IDLE: begin
               txd_o <= 1'b1;
               if (buf_pop) begin
                  shift <= buf_data;
                  // last data index is width minus one, i.e. code plus 4
                  width_m1 <= {1'b0, line_ctrl[1:0]} + 3'd4;
                  two_stops <= line_ctrl[`RSDC_LCR_STOP];
                  txd_o <= 1'b0;
                  state <= ST_START;
               end
            end
            ST_START: begin
               if (tick) begin
                  txd_o <= shift[0];
                  shift <= {1'b0, shift[7:1]};
                  bit_idx <= 3'd0;
                  state <= ST_DATA;
               end
            end
            ST_DATA: begin
               if (tick) begin
                  if (bit_idx == width_m1) begin
                     txd_o <= 1'b1;
                     stop_idx <= 1'b0;
                     state <= ST_STOP;
                  end else begin
                     txd_o <= shift[0];
                     shift <= {1'b0, shift[7:1]};
                     bit_idx <= bit_idx + 3'd1;
                  end
               end
            end
            ST_STOP: begin
               if (tick) begin
                  if (two_stops & ~stop_idx)
                     stop_idx <= 1'b1;
                  else
                     state <= ST_IDLE;
               end
            end
            default: state <= ST_IDLE;
         endcase
      end
   end

   // line driver enable
   always @(posedge core_clk_i) begin
      if (srst_i)
         drv_en_o <= 1'b0;
      else if (auto_mode)
         // data waiting or frame still leaving
         drv_en_o <= buf_valid | busy;
      else
         drv_en_o <= modem_control[`RSDC_MCR_RTS];
   end
endmodule

// *** pkg/rsdc_consts.vh ***
// constants for the rs485 transmit uart with direction control
// assumes inclusion by bare name from the design files
`ifndef RSDC_CONSTS_VH
`define RSDC_CONSTS_VH
`define RSDC_OFS_DATA 3'h0
`define RSDC_OFS_DIVHI 3'h1
`define RSDC_OFS_LCTRL 3'h3
`define RSDC_OFS_MCTRL 3'h4
`define RSDC_OFS_LSTAT 3'h5
`define RSDC_OFS_SCRATCH 3'h7
`define RSDC_MCR_RTS 1
`define RSDC_MCR_AUTO 4
`define RSDC_LSR_THRE 5
`define RSDC_LSR_TEMT 6
`define RSDC_LCR_DIVISOR_LATCH_ACCESS_BIT 7
`define RSDC_LCR_STOP 2
`define RSDC_RST_DIV 16'h000c
`define RSDC_RST_LCR 8'h03
`define RSDC_RST_MCR 8'h00
`define RSDC_CLK_HZ 50000000
`define RSDC_CLK_16X 16
`endif

// *** src/rsdc_buf2.v ***
// two-entry buffer between register write and the shifter
// assumes both sides on core_clk_i, synchronous reset
`timescale 1ns/1ns
module rsdc_buf2 #(
   parameter WIDTH = 8
) (
   input wire core_clk_i,
   input wire srst_i,
   input wire in_valid_i,
   output wire in_ready_o,
   input wire [WIDTH-1:0] in_data_i,
   output wire out_valid_o,
   input wire out_ready_i,
   output wire [WIDTH-1:0] out_data_o
);
   reg [WIDTH-1:0] mem [0:1];
   reg wr_ptr;
   reg rd_ptr;
   reg [1:0] count;
   wire push;
   wire pop;

   // honest full and empty from the occupancy count
   assign in_ready_o = (count != 2'd2);
   assign out_valid_o = (count != 2'd0);
   assign out_data_o = mem[rd_ptr];
   assign push = in_valid_i & in_ready_o;
   assign pop = out_valid_o & out_ready_i;

   // pointer and count update
   always @(posedge core_clk_i) begin
      if (srst_i) begin
         wr_ptr <= 1'b0;
         rd_ptr <= 1'b0;
         count <= 2'd0;
      end else begin
         if (push) begin
            mem[wr_ptr] <= in_data_i;
            wr_ptr <= ~wr_ptr;
         end
         if (pop)
            rd_ptr <= ~rd_ptr;
         if (push & ~pop)
            count <= count + 2'd1;
         else if (pop & ~push)
            count <= count - 2'd1;
      end
   end
endmodule

// *** verification/rsdc_uart_tx_assertions.sv ***
// checker on the ports of the rs485 transmit uart
// assumes divisor 1, so one bit lasts 16 core cycles
`timescale 1ns/1ns
module rsdc_uart_tx_assertions (
   input wire core_clk_i,
   input wire srst_i,
   input wire [9:0] io_base_i,
   input wire [9:0] io_addr_i,
   input wire io_wr_i,
   input wire io_rd_i,
   input wire [7:0] io_wdata_i,
   input wire [7:0] io_rdata_o,
   input wire cts_n_i,
   input wire txd_o,
   input wire drv_en_o,
   input wire rts_o
);
   default clocking @(posedge core_clk_i); endclocking
   default disable iff (srst_i);
   wire hit = io_addr_i[9:3] == io_base_i[9:3];
   wire [2:0] ofs = io_addr_i[2:0];
   wire mw = io_wr_i && hit && ofs == 3'h4;
   wire wr_rts = io_wdata_i[1];
   reg amode;
   // shadow of the auto direction bit, same edge as the design
   always @(posedge core_clk_i) begin
      if (srst_i)
         amode <= 1'b0;
      else if (mw)
         amode <= io_wdata_i[4];
   end
   sequence s_fall; $fell(txd_o); endsequence
   sequence s_low; (!txd_o)[*8] ##1 (!txd_o)[*8]; endsequence
   property p_start; s_fall |-> s_low; endproperty
   property p_rts; mw |=> rts_o == $past(wr_rts); endproperty
   property p_on; amode && $fell(txd_o) |-> drv_en_o; endproperty
   property p_hold; amode && !txd_o |-> drv_en_o; endproperty
   property p_rel;
      amode && $fell(drv_en_o) |-> $past(txd_o, 16) && $past(txd_o);
   endproperty
   property p_man; !amode && !$past(amode) |-> drv_en_o == $past(rts_o);
   endproperty
   property p_dec; io_rd_i && !hit |=> $stable(io_rdata_o); endproperty
   property p_gap;
      io_rd_i && hit && (ofs == 3'h2 || ofs == 3'h6) |=> io_rdata_o == 8'h00;
   endproperty
   a_start: assert property (p_start) else $error("start bit length");
   a_rts: assert property (p_rts) else $error("rts level");
   a_on: assert property (p_on) else $error("driver off at start");
   a_hold: assert property (p_hold) else $error("driver off");
   a_rel: assert property (p_rel) else $error("early release");
   a_man: assert property (p_man) else $error("manual driver");
   a_dec: assert property (p_dec) else $error("foreign read");
   a_gap: assert property (p_gap) else $error("unmapped read");
endmodule

// *** verification/rsdc_line_node.sv ***
// far node on the shared pair: decodes frames it sees
// assumes BIT core cycles per bit and a biased idle-high pair
`timescale 1ns/1ns
module rsdc_line_node #(
   parameter BIT = 16
) (
   input wire core_clk_i,
   input wire txd_i,
   input wire drv_en_i,
   input wire [3:0] wid_i,
   output reg [7:0] rx_o,
   output reg stb_o
);
   // only a driven level reaches the pair
   wire line = drv_en_i ? txd_i : 1'b1;
   integer i;
   initial stb_o = 1'b0;
   // mid-bit sampling, lsb first; a low stop bit gives no strobe
   always begin
      @(negedge line);
      repeat (BIT / 2) @(posedge core_clk_i);
      rx_o = 8'h00;
      for (i = 0; i < wid_i; i = i + 1) begin
         repeat (BIT) @(posedge core_clk_i);
         rx_o[i] = line;
      end
      repeat (BIT) @(posedge core_clk_i);
      stb_o = line;
      @(posedge core_clk_i);
      stb_o = 1'b0;
   end
endmodule

// *** verification/rs485_uart_direction_control_test.sv ***
// bench for the rs485 transmit uart with direction control
// assumes the line node model and the bound checker
`timescale 1ns/1ns
bind rsdc_uart_tx rsdc_uart_tx_assertions rsdc_chk (.core_clk_i(core_clk_i),
   .srst_i(srst_i), .io_base_i(io_base_i), .io_addr_i(io_addr_i),
   .io_wr_i(io_wr_i), .io_rd_i(io_rd_i), .io_wdata_i(io_wdata_i),
   .io_rdata_o(io_rdata_o), .cts_n_i(cts_n_i), .txd_o(txd_o),
   .drv_en_o(drv_en_o), .rts_o(rts_o));
module rs485_uart_direction_control_test;
   reg core_clk_i = 1'b0;
   reg srst_i = 1'b1;
   reg [9:0] io_base_i = 10'h000;
   reg [9:0] io_addr_i = 10'h000;
   reg io_wr_i = 1'b0;
   reg io_rd_i = 1'b0;
   reg [7:0] io_wdata_i = 8'h00;
   reg cts_n_i = 1'b1; // deasserted, must not stall
   reg [6:0] hi = 7'h00;
   reg [3:0] wid = 4'h8;
   reg [7:0] d, m;
   reg [7:0] exp_q[$];
   wire [7:0] io_rdata_o, rx;
   wire txd_o, drv_en_o, rts_o, stb;
   integer err_count = 0, n_tests = 0, k, j;
   rsdc_uart_tx rsdc_uart_tx_inst (.core_clk_i(core_clk_i), .srst_i(srst_i),
      .io_base_i(io_base_i), .io_addr_i(io_addr_i), .io_wr_i(io_wr_i),
      .io_rd_i(io_rd_i), .io_wdata_i(io_wdata_i), .io_rdata_o(io_rdata_o),
      .cts_n_i(cts_n_i), .txd_o(txd_o), .drv_en_o(drv_en_o), .rts_o(rts_o));
   rsdc_line_node rsdc_line_node_inst (.core_clk_i(core_clk_i), .txd_i(txd_o),
      .drv_en_i(drv_en_o), .wid_i(wid), .rx_o(rx), .stb_o(stb));
   task chk(input [7:0] seen, input [7:0] exp);
      begin
         n_tests = n_tests + 1;
         if (seen !== exp) begin
            err_count = err_count + 1;
            $display("[FAIL] %0t got %h want %h", $time, seen, exp);
         end
      end
   endtask
   // one bus access; read data lands with the strobe edge
   task acc(input w, input [2:0] o, input [7:0] v);
      begin
         @(posedge core_clk_i);
         #2;
         io_addr_i = {io_base_i[9:3] ^ hi, o};
         io_wdata_i = v;
         io_wr_i = w;
         io_rd_i = !w;
         @(posedge core_clk_i);
         #2;
         io_wr_i = 1'b0;
         io_rd_i = 1'b0;
         d = io_rdata_o;
      end
   endtask
   // poll the buffer-has-room flag, then write one byte
   task send(input [7:0] v);
      begin
         k = 0;
         acc(1'b0, 3'h5, 8'h00);
         while (d[5] !== 1'b1 && k < 500) begin
            acc(1'b0, 3'h5, 8'h00);
            k = k + 1;
         end
         chk(d & 8'h20, 8'h20);
         acc(1'b1, 3'h0, v);
         exp_q.push_back(v & (8'hff >> (8 - wid)));
      end
   endtask
   // bounded wait for buffer empty and shifter idle
   task drain;
      begin
         k = 0;
         acc(1'b0, 3'h5, 8'h00);
         while (d !== 8'h60 && k < 2000) begin
            acc(1'b0, 3'h5, 8'h00);
            k = k + 1;
         end
         chk(d, 8'h60);
      end
   endtask
   task wrap_up;
      begin
         $display("mismatches %0d checks %0d", err_count, n_tests);
         if (err_count == 0 && n_tests > 0)
            $display("All tests passed");
         else
            $display("Some tests failed");
         $finish;
      end
   endtask
   // each frame seen on the pair retires the oldest note
   always @(posedge stb) begin
      if (exp_q.size() == 0)
         chk(8'h00, 8'hff);
      else
         chk(rx, exp_q.pop_front());
   end
   initial begin
      forever #10 core_clk_i = ~core_clk_i;
   end
   // hang guard, well past the longest expected run
   initial begin
      #(20 * 30000);
      err_count = err_count + 1;
      wrap_up;
   end
   initial begin
      k = $urandom(32'h4e4e_4dcf);
      io_base_i = 10'($urandom) & 10'h3f8;
      repeat (12) @(posedge core_clk_i);
      #2;
      srst_i = 1'b0;
      acc(1'b0, 3'h4, 8'h00);
      chk(d, 8'h00);
      // divisor 1 loaded, then latch bit cleared
      acc(1'b1, 3'h3, 8'h80);
      acc(1'b1, 3'h0, 8'h01);
      acc(1'b1, 3'h1, 8'h00);
      acc(1'b1, 3'h3, 8'h03);
      // auto mode with rts low; fourth byte overflows the buffer
      acc(1'b1, 3'h4, 8'h10);
      send(8'($urandom));
      repeat (4) @(posedge core_clk_i);
      for (j = 0; j < 3; j = j + 1) begin
         m = 8'($urandom);
         acc(1'b1, 3'h0, m);
         if (j < 2)
            exp_q.push_back(m);
      end
      acc(1'b0, 3'h5, 8'h00);
      chk(d, 8'h00);
      drain;
      // manual with rts low: frame leaves undriven, node sees nothing
      acc(1'b1, 3'h4, 8'h00);
      acc(1'b1, 3'h0, 8'h5a);
      drain;
      // foreign window: write dropped, read leaves data alone
      hi = 7'h01;
      acc(1'b1, 3'h0, 8'ha5);
      acc(1'b0, 3'h4, 8'h00);
      hi = 7'h00;
      chk(d, 8'h60);
      acc(1'b0, 3'h5, 8'h00);
      chk(d, 8'h60);
      acc(1'b0, 3'h4, 8'h00);
      acc(1'b1, 3'h4, d | 8'h02);
      chk({7'h00, rts_o}, 8'h01);
      for (j = 0; j < 3; j = j + 1)
         send(8'($urandom));
      drain;
      acc(1'b0, 3'h4, 8'h00);
      acc(1'b1, 3'h4, d & 8'hfd);
      @(posedge core_clk_i);
      #2;
      chk({7'h00, drv_en_o}, 8'h00);
      acc(1'b0, 3'h2, 8'h00);
      chk(d, 8'h00);
      // five-bit characters, two stops, auto again
      wid = 4'h5;
      acc(1'b1, 3'h3, 8'h04);
      // auto with request-to-send high still releases
      acc(1'b1, 3'h4, 8'h12);
      send(8'($urandom));
      send(8'($urandom));
      drain;
      chk({7'h00, drv_en_o}, 8'h00);
      chk(8'(exp_q.size()), 8'h00);
      wrap_up;
   end
endmodule
